// *** shared/hcs_pkg.sv ***
// Purpose: shared constants, types and state layout of the serial frame check path
// Assumes: mclk at 40 MHz samples both bit clocks; serial bytes go LSB first
// Notes:   crc register holds the X^31 term in bit 31
package hcs_pkg;

    // ----------------------------------------------------------------
    // frame check constants
    // ----------------------------------------------------------------
    localparam logic [31:0] HCS_CRC_POLY    = 32'h04C11DB7;
    localparam logic [31:0] HCS_CRC_PRESET  = 32'hFFFFFFFF;
    localparam logic [31:0] HCS_CRC_RESIDUE = 32'hC704DD7B;
    localparam logic [4:0]  HCS_FCS_LAST    = 5'h1F;
    localparam logic        HCS_CRC_SEL_32  = 1'h0;

    // ----------------------------------------------------------------
    // framing constants
    // ----------------------------------------------------------------
    localparam logic [7:0] HCS_FLAG_BYTE    = 8'h7E;
    localparam logic [2:0] HCS_STUFF_ONES   = 3'h5;
    localparam logic [2:0] HCS_FLAG_ONES    = 3'h6;
    localparam logic [2:0] HCS_ABORT_ONES   = 3'h7;
    localparam logic [2:0] HCS_RX_DELAY     = 3'h7;
    localparam logic [2:0] HCS_BIT_LAST     = 3'h7;
    localparam logic [2:0] HCS_MIN_BYTES    = 3'h4;

    // ----------------------------------------------------------------
    // output source select and reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] HCS_SRC_FRAMED   = 2'h0;
    localparam logic [1:0] HCS_SRC_CLEAR    = 2'h1;
    localparam logic [1:0] HCS_SRC_STATIC   = 2'h2;
    localparam logic       HCS_LINE_IDLE    = 1'h1;
    // rx clock and data idle high, tx clock low: no false edge after reset
    localparam logic [3:0] HCS_SYNC_IDLE    = 4'hE;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        HCS_TX_FLAG = 3'b001,
        HCS_TX_DATA = 3'b010,
        HCS_TX_FCS  = 3'b100
    } hcs_tx_e;

    typedef enum logic [1:0] {
        HCS_RX_HUNT  = 2'b01,
        HCS_RX_FRAME = 2'b10
    } hcs_rx_e;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } hcs_tx_req_s;

    typedef struct packed {
        logic [7:0] data;
        logic       byteValid;
        logic       frameGood;
        logic       crcInvalid;
        logic       abort;
    } hcs_rx_evt_s;

    // sync vector order: {hostIn, rxData, rxClk, txClk}
    typedef struct packed {
        logic [3:0]  syncA;
        logic [3:0]  syncB;
        logic        txClkPrev;
        logic        rxClkPrev;
        hcs_tx_e     txState;
        logic [2:0]  txBitIdx;
        logic [7:0]  txShift;
        logic [2:0]  txOnes;
        logic [31:0] txCrc;
        logic [4:0]  fcsIdx;
        logic        txLastSeen;
        logic [7:0]  holdData;
        logic        holdValid;
        logic        holdLast;
        logic        txBit;
        logic        serialOut;
        hcs_rx_e     rxState;
        logic [2:0]  rxOnes;
        logic [6:0]  rxDly;
        logic [2:0]  rxDlyCnt;
        logic [31:0] rxCrc;
        logic [7:0]  rxAsm;
        logic [2:0]  rxBitCnt;
        logic [2:0]  rxByteCnt;
        hcs_rx_evt_s rxEvt;
    } hcs_state_s;

endpackage : hcs_pkg

// *** test/hcs_modem_model.sv ***
// Purpose: modem model, free-running bit clocks, serial loopback
// Assumes: 200 ns bit period, tx bits settle well before the next tx fall
// Notes:   corrupt flips the looped bit while high
`timescale 1ns/10ps
`default_nettype none

module hcs_modem_model (
    // serial pins
    input  wire logic txData,
    output logic      txClk,
    output logic      rxClk,
    output logic      rxData,
    // fault injection
    input  wire logic corrupt
);
    // ----------------------------------------------------------------
    // clocks and loopback
    // ----------------------------------------------------------------
    initial begin
        txClk  = 1'b1;
        rxData = 1'b1;
    end

    always #100 txClk = ~txClk;

    // bit taken just before the next tx fall, resent for the rx rise
    always @(negedge txClk) begin
        rxData <= txData ^ corrupt;
    end

    assign #5 rxClk = txClk;
endmodule : hcs_modem_model
`default_nettype wire

// *** test/hcs_serial_path_sva.sv ***
// Purpose: port-level assertions of the serial frame check path
// Assumes: bit clocks sampled raw by mclk
// Notes:   fall and rise ages counted in helper logic
`timescale 1ns/10ps
`default_nettype none

module hcs_serial_path_sva (
    // clock and reset
    input wire logic                 mclk,
    input wire logic                 rst_n,
    // serial pins
    input wire logic                 packet_tx_bit_clock,
    input wire logic                 packet_serial_out,
    input wire logic                 packet_rx_bit_clock,
    input wire logic                 packet_serial_in,
    // configuration
    input wire logic                 hostSerialIn,
    input wire logic [1:0]           srcSel,
    input wire logic                 staticLevel,
    input wire logic                 crcSel,
    // byte ports
    input wire hcs_pkg::hcs_tx_req_s txReq,
    input wire logic                 txReady,
    input wire hcs_pkg::hcs_rx_evt_s rxEvt
);
    // ----------------------------------------------------------------
    // edge ages and assertions
    // ----------------------------------------------------------------
    logic       txPrev_ff;
    logic       rxPrev_ff;
    logic [3:0] txAge_ff;
    logic [3:0] rxAge_ff;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            txPrev_ff <= 1'b1;
            rxPrev_ff <= 1'b1;
            txAge_ff  <= 4'hF;
            rxAge_ff  <= 4'hF;
        end else begin
            txPrev_ff <= packet_tx_bit_clock;
            rxPrev_ff <= packet_rx_bit_clock;
            txAge_ff  <= (txPrev_ff && !packet_tx_bit_clock) ? 4'h0 : txAge_ff + {3'h0, txAge_ff != 4'hF};
            rxAge_ff  <= (!rxPrev_ff && packet_rx_bit_clock) ? 4'h0 : rxAge_ff + {3'h0, rxAge_ff != 4'hF};
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_static_hold;
        (srcSel == hcs_pkg::HCS_SRC_STATIC && $stable(staticLevel))[*6];
    endsequence
    sequence s_clear_hold;
        (srcSel == hcs_pkg::HCS_SRC_CLEAR && $stable(hostSerialIn))[*6];
    endsequence

    a_static_level_out: assert property (s_static_hold |-> packet_serial_out == staticLevel)
        else $error("static level not on serial out");
    a_clear_channel_out: assert property (s_clear_hold |-> packet_serial_out == hostSerialIn)
        else $error("host input not on serial out");
    a_idle_code_high: assert property ((srcSel == 2'h3)[*6] |-> packet_serial_out)
        else $error("idle select not high");
    a_ready_after_take: assert property (txReq.valid && txReady |=> !txReady)
        else $error("byte offer not taken");
    a_out_after_txfall: assert property ($changed(packet_serial_out) && srcSel == hcs_pkg::HCS_SRC_FRAMED
        && $past(srcSel, 4) == hcs_pkg::HCS_SRC_FRAMED |-> txAge_ff inside {[1:7]})
        else $error("framed bit moved without tx clock fall");
    a_byte_after_rxrise: assert property (rxEvt.byteValid |-> rxAge_ff inside {[1:7]})
        else $error("byte event without rx clock rise");
    a_verdict_one_pulse: assert property (rxEvt.frameGood || rxEvt.crcInvalid
        |=> !(rxEvt.frameGood || rxEvt.crcInvalid))
        else $error("frame verdict longer than one cycle");
    a_verdict_exclusive: assert property (!(rxEvt.frameGood && rxEvt.crcInvalid))
        else $error("good and invalid together");
endmodule : hcs_serial_path_sva
`default_nettype wire

// *** test/test_hcs_serial_path.sv ***
// Purpose: self-checking bench for the serial frame check path
// Assumes: modem model loops the tx stream back into rx
// Notes:   crcSel at the 32-bit setting except in the no-check scenario
`timescale 1ns/10ps
`default_nettype none

module test_hcs_serial_path;
    // ----------------------------------------------------------------
    // stimulus, scoreboard and scenarios
    // ----------------------------------------------------------------
    logic                 mclk    = 1'b0;
    logic                 rst_n   = 1'b0;
    logic                 hostIn  = 1'b0;
    logic                 statLvl = 1'b0;
    logic                 corrupt = 1'b0;
    logic [1:0]           srcSel  = hcs_pkg::HCS_SRC_FRAMED;
    logic                 crcSel  = hcs_pkg::HCS_CRC_SEL_32;
    logic                 txClk, rxClk, rxData, serOut, txReady;
    hcs_pkg::hcs_tx_req_s txReq   = '0;
    hcs_pkg::hcs_rx_evt_s rxEvt;
    logic [7:0]           rxQ[$];
    int                   err_count = 0, num_checks = 0, goodCnt = 0, badCnt = 0, cyc = 0;
    int                   abortCnt = 0, flipLen = 1;

    always #12.5 mclk = ~mclk;

    hcs_serial_path u_hcs_serial_path (.mclk(mclk), .rst_n(rst_n), .packet_tx_bit_clock(txClk),
        .packet_serial_out(serOut), .packet_rx_bit_clock(rxClk), .packet_serial_in(rxData),
        .hostSerialIn(hostIn), .srcSel(srcSel), .staticLevel(statLvl),
        .crcSel(crcSel), .txReq(txReq), .txReady(txReady), .rxEvt(rxEvt));
    hcs_modem_model u_modem (.txData(serOut), .txClk(txClk), .rxClk(rxClk), .rxData(rxData),
        .corrupt(corrupt));

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (rxEvt.byteValid === 1'b1) rxQ.push_back(rxEvt.data);
        if (rxEvt.frameGood === 1'b1) goodCnt <= goodCnt + 1;
        if (rxEvt.crcInvalid === 1'b1) badCnt <= badCnt + 1;
        if (rxEvt.abort === 1'b1) abortCnt <= abortCnt + 1;
        if (cyc == 60000) begin
            err_count++;
            wrap_up();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic b);
        return (c << 1) ^ ((c[31] ^ b) ? hcs_pkg::HCS_CRC_POLY : 32'h00000000);
    endfunction : crc_step

    // offers a frame, waits for its verdict; flipAt < 0 means clean
    task automatic send_frame(input logic [7:0] bytes[$], input int flipAt);
        logic [31:0] crc;
        int          n;
        int          g;
        int          b;
        int          a;
        crc = hcs_pkg::HCS_CRC_PRESET;
        g = goodCnt;
        b = badCnt;
        a = abortCnt;
        rxQ.delete();
        foreach (bytes[i]) begin
            n = 0;
            while (txReady !== 1'b1 && n < 4000) begin
                @(negedge mclk);
                n++;
            end
            txReq = {1'b1, i == bytes.size() - 1, bytes[i]};
            @(negedge mclk);
            txReq.valid = 1'b0;
            for (int k = 0; k < 8; k++) crc = crc_step(crc, bytes[i][k]);
            if (i == flipAt) begin
                @(negedge txClk);
                #10 corrupt = 1'b1;
                repeat (flipLen) @(negedge txClk);
                #10 corrupt = 1'b0;
            end
        end
        n = 0;
        while (goodCnt == g && badCnt == b && abortCnt == a && n < (crcSel ? 1200 : 6000)) begin
            @(negedge mclk);
            n++;
        end
        if (crcSel != hcs_pkg::HCS_CRC_SEL_32) begin
            check(goodCnt + badCnt - g - b, 0);
            check(rxQ.size(), bytes.size());
            foreach (bytes[i]) check(rxQ[i], bytes[i]);
        end else if (flipAt < 0) begin
            check(goodCnt - g, 1);
            check(badCnt - b, 0);
            check(abortCnt - a, 0);
            check(rxQ.size(), bytes.size() + 4);
            foreach (bytes[i]) check(rxQ[i], bytes[i]);
            for (int k = 0; k < 32; k++) check(rxQ[bytes.size() + k / 8][k % 8], !crc[31 - k]);
        end else begin
            check(badCnt - b, flipLen == 1);
            check(goodCnt - g, 0);
            check(abortCnt - a, flipLen > 1);
        end
        $display("test frame of %0d bytes done", bytes.size());
    endtask : send_frame

    task automatic t_idle_flags();
        repeat (400) @(negedge mclk);
        check(rxQ.size(), 0);
        check(goodCnt + badCnt + abortCnt, 0);
        $display("test idle flags done");
    endtask : t_idle_flags

    task automatic t_src_select();
        logic [1:0] sels[5] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h3};
        logic       lv[5]   = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
        for (int k = 0; k < 5; k++) begin
            @(negedge mclk);
            srcSel  = sels[k];
            hostIn  = (sels[k] == 2'h1) ? lv[k] : ~lv[k];
            statLvl = (sels[k] == 2'h2) ? lv[k] : ~lv[k];
            repeat (8) @(negedge mclk);
            check(serOut, lv[k]);
        end
        $display("test source select done");
    endtask : t_src_select

    // non-32-bit crcSel setting: no check sequence sent, no verdict reported
    task automatic t_no_fcs();
        @(negedge mclk);
        crcSel = ~hcs_pkg::HCS_CRC_SEL_32;
        send_frame('{8'h5A, 8'hC3}, -1);
        crcSel = hcs_pkg::HCS_CRC_SEL_32;
    endtask : t_no_fcs

    // twelve zeros turned to ones: abort, then no verdict for the frame
    task automatic t_abort();
        int v;
        v = goodCnt + badCnt;
        flipLen = 12;
        send_frame('{8'h00, 8'h00, 8'h00}, 1);
        flipLen = 1;
        repeat (1000) @(negedge mclk);
        check(goodCnt + badCnt, v);
        $display("test abort done");
    endtask : t_abort

    initial begin
        repeat (12) @(negedge mclk);
        check(serOut, 1'b1);
        check(txReady, 1'b1);
        check(rxEvt, '0);
        rst_n = 1'b1;
        t_idle_flags();
        send_frame('{8'h01, 8'hFF, 8'h7E, 8'h3C}, -1);
        send_frame('{8'hA5}, -1);
        send_frame('{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 2);
        send_frame('{8'h1F, 8'hF8}, -1);
        t_no_fcs();
        t_abort();
        t_src_select();
        wrap_up();
    end
endmodule : test_hcs_serial_path

bind hcs_serial_path hcs_serial_path_sva u_sva (.mclk(mclk), .rst_n(rst_n),
    .packet_tx_bit_clock(packet_tx_bit_clock), .packet_serial_out(packet_serial_out),
    .packet_rx_bit_clock(packet_rx_bit_clock), .packet_serial_in(packet_serial_in),
    .hostSerialIn(hostSerialIn), .srcSel(srcSel), .staticLevel(staticLevel), .crcSel(crcSel),
    .txReq(txReq), .txReady(txReady), .rxEvt(rxEvt));
`default_nettype wire

// *** verilog/hcs_crc32_step.sv ***
// Purpose: one serial step of the 32-bit frame check generator
// Assumes: combinational; caller registers the result
// Notes:   msb-first shift, feedback taken from bit 31
`timescale 1ns/10ps
`default_nettype none

module hcs_crc32_step (
    // crc in and out
    input  wire logic [31:0] crcIn,
    input  wire logic        dataBit,
    output logic      [31:0] crcOut
);

    // ----------------------------------------------------------------
    // feedback
    // ----------------------------------------------------------------
    logic feedback;

    always_comb begin
        feedback = crcIn[31] ^ dataBit;
        crcOut   = {crcIn[30:0], 1'b0} ^ (feedback ? hcs_pkg::HCS_CRC_POLY : 32'h00000000);
    end

endmodule : hcs_crc32_step
`default_nettype wire

// *** verilog/hcs_serial_path.sv ***
// Purpose: framed serial transmit and receive path with 32-bit frame check
// Assumes: bit clocks and serial inputs are asynchronous to mclk
// Notes:   tx bits change on tx bit clock falls, rx bits taken on rx bit clock rises
// Function
// - tx crc covers data bits after opening flag up to fcs, skipping stuffed zeros
// - tx crc preset to all ones before each frame
// - each bit processed with the standard 32-bit generator polynomial
// - fcs sent as inverted crc, most significant bit first
// - rx crc preset to all ones after an opening flag
// - rx crc ignores stuffed zeros from the sender
// - good frame leaves the fixed residue in the rx crc
// - wrong residue at frame end raises an invalid-crc indication
// - serial output selects framed stream, clear-channel host input, or static level
// - tx data shifted out under the externally supplied tx bit clock
// - rx data sampled with the separate rx bit clock from the modem
// - bytes sent lsb first at byte boundary with automatic zero insertion
`timescale 1ns/10ps
`default_nettype none

module hcs_serial_path (
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               rst_n,
    // serial pins
    input  wire logic               packet_tx_bit_clock,
    output logic                    packet_serial_out,
    input  wire logic               packet_rx_bit_clock,
    input  wire logic               packet_serial_in,
    // configuration
    input  wire logic               hostSerialIn,
    input  wire logic [1:0]         srcSel,
    input  wire logic               staticLevel,
    input  wire logic               crcSel,
    // transmit byte port
    input  wire hcs_pkg::hcs_tx_req_s txReq,
    output logic                    txReady,
    // receive events
    output hcs_pkg::hcs_rx_evt_s    rxEvt
);

    // ----------------------------------------------------------------
    // state and crc steps
    // ----------------------------------------------------------------
    hcs_pkg::hcs_state_s cur_ff;
    hcs_pkg::hcs_state_s nxt_state;
    logic [31:0]         txCrcStep;
    logic [31:0]         rxCrcStep;
    logic                rxExitBit;

    assign rxExitBit = cur_ff.rxDly[0];

    hcs_crc32_step u_tx_crc (
        .crcIn   (cur_ff.txCrc),
        .dataBit (cur_ff.txShift[0]),
        .crcOut  (txCrcStep)
    );

    hcs_crc32_step u_rx_crc (
        .crcIn   (cur_ff.rxCrc),
        .dataBit (rxExitBit),
        .crcOut  (rxCrcStep)
    );

    assign txReady           = ~cur_ff.holdValid;
    assign packet_serial_out = cur_ff.serialOut;
    assign rxEvt             = cur_ff.rxEvt;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic txFall;
    logic rxRise;
    logic rxBit;
    logic crc32On;
    logic [2:0] onesInc;
    logic pushBit;

    always_comb begin
        nxt_state = cur_ff;
        crc32On   = (crcSel == hcs_pkg::HCS_CRC_SEL_32);
        pushBit   = 1'b0;
        onesInc   = 3'h0;

        // two-stage synchronisers, second stage feeds everything
        nxt_state.syncA     = {hostSerialIn, packet_serial_in, packet_rx_bit_clock, packet_tx_bit_clock};
        nxt_state.syncB     = cur_ff.syncA;
        nxt_state.txClkPrev = cur_ff.syncB[0];
        nxt_state.rxClkPrev = cur_ff.syncB[1];
        txFall = cur_ff.txClkPrev & ~cur_ff.syncB[0];
        rxRise = ~cur_ff.rxClkPrev & cur_ff.syncB[1];
        rxBit  = cur_ff.syncB[2];

        // one-cycle event pulses
        nxt_state.rxEvt.byteValid  = 1'b0;
        nxt_state.rxEvt.frameGood  = 1'b0;
        nxt_state.rxEvt.crcInvalid = 1'b0;
        nxt_state.rxEvt.abort      = 1'b0;

        // hold register for the next tx byte
        if (txReq.valid && !cur_ff.holdValid) begin
            nxt_state.holdData  = txReq.data;
            nxt_state.holdLast  = txReq.last;
            nxt_state.holdValid = 1'b1;
        end

        // ------------------------------------------------------------
        // transmit
        // ------------------------------------------------------------
        if (txFall) begin
            case (cur_ff.txState)
                hcs_pkg::HCS_TX_FLAG: begin
                    if (cur_ff.txOnes == hcs_pkg::HCS_STUFF_ONES) begin
                        // frame closed on five ones: stuff before the flag
                        nxt_state.txBit  = 1'b0;
                        nxt_state.txOnes = 3'h0;
                    end else begin
                        nxt_state.txBit    = hcs_pkg::HCS_FLAG_BYTE[cur_ff.txBitIdx];
                        nxt_state.txBitIdx = cur_ff.txBitIdx + 3'h1;
                        if (cur_ff.txBitIdx == hcs_pkg::HCS_BIT_LAST && cur_ff.holdValid) begin
                            nxt_state.txState    = hcs_pkg::HCS_TX_DATA;
                            nxt_state.txShift    = cur_ff.holdData;
                            nxt_state.txLastSeen = cur_ff.holdLast;
                            nxt_state.holdValid  = 1'b0;
                            nxt_state.txCrc      = hcs_pkg::HCS_CRC_PRESET;
                            nxt_state.txOnes     = 3'h0;
                        end
                    end
                end
                hcs_pkg::HCS_TX_DATA: begin
                    if (cur_ff.txOnes == hcs_pkg::HCS_STUFF_ONES) begin
                        nxt_state.txBit  = 1'b0;
                        nxt_state.txOnes = 3'h0;
                    end else begin
                        nxt_state.txBit    = cur_ff.txShift[0];
                        nxt_state.txCrc    = txCrcStep;
                        nxt_state.txOnes   = cur_ff.txShift[0] ? cur_ff.txOnes + 3'h1 : 3'h0;
                        nxt_state.txShift  = {1'b0, cur_ff.txShift[7:1]};
                        nxt_state.txBitIdx = cur_ff.txBitIdx + 3'h1;
                        if (cur_ff.txBitIdx == hcs_pkg::HCS_BIT_LAST) begin
                            if (!cur_ff.txLastSeen && cur_ff.holdValid) begin
                                nxt_state.txShift    = cur_ff.holdData;
                                nxt_state.txLastSeen = cur_ff.holdLast;
                                nxt_state.holdValid  = 1'b0;
                            end else begin
                                // last byte done, or underrun closes the frame
                                nxt_state.fcsIdx  = 5'h00;
                                nxt_state.txState = crc32On ? hcs_pkg::HCS_TX_FCS : hcs_pkg::HCS_TX_FLAG;
                            end
                        end
                    end
                end
                hcs_pkg::HCS_TX_FCS: begin
                    if (cur_ff.txOnes == hcs_pkg::HCS_STUFF_ONES) begin
                        nxt_state.txBit  = 1'b0;
                        nxt_state.txOnes = 3'h0;
                    end else begin
                        nxt_state.txBit  = ~cur_ff.txCrc[31];
                        nxt_state.txOnes = ~cur_ff.txCrc[31] ? cur_ff.txOnes + 3'h1 : 3'h0;
                        nxt_state.txCrc  = {cur_ff.txCrc[30:0], 1'b0};
                        nxt_state.fcsIdx = cur_ff.fcsIdx + 5'h01;
                        if (cur_ff.fcsIdx == hcs_pkg::HCS_FCS_LAST) begin
                            nxt_state.txState  = hcs_pkg::HCS_TX_FLAG;
                            nxt_state.txBitIdx = 3'h0;
                        end
                    end
                end
                default: begin
                    nxt_state.txState  = hcs_pkg::HCS_TX_FLAG;
                    nxt_state.txBitIdx = 3'h0;
                end
            endcase
        end

        // output source select
        case (srcSel)
            hcs_pkg::HCS_SRC_FRAMED: nxt_state.serialOut = cur_ff.txBit;
            hcs_pkg::HCS_SRC_CLEAR:  nxt_state.serialOut = cur_ff.syncB[3];
            hcs_pkg::HCS_SRC_STATIC: nxt_state.serialOut = staticLevel;
            default:                 nxt_state.serialOut = hcs_pkg::HCS_LINE_IDLE;
        endcase

        // ------------------------------------------------------------
        // receive
        // ------------------------------------------------------------
        if (rxRise) begin
            onesInc = (cur_ff.rxOnes == hcs_pkg::HCS_ABORT_ONES) ? cur_ff.rxOnes : cur_ff.rxOnes + 3'h1;
            if (rxBit) begin
                nxt_state.rxOnes = onesInc;
                if (onesInc == hcs_pkg::HCS_ABORT_ONES) begin
                    if (cur_ff.rxState == hcs_pkg::HCS_RX_FRAME) begin
                        nxt_state.rxEvt.abort = 1'b1;
                    end
                    nxt_state.rxState = hcs_pkg::HCS_RX_HUNT;
                end else begin
                    pushBit = 1'b1;
                end
            end else begin
                nxt_state.rxOnes = 3'h0;
                if (cur_ff.rxOnes == hcs_pkg::HCS_FLAG_ONES) begin
                    // flag: close any frame, then open a new one
                    if (cur_ff.rxState == hcs_pkg::HCS_RX_FRAME && crc32On &&
                        (cur_ff.rxByteCnt != 3'h0 || cur_ff.rxBitCnt != 3'h0)) begin
                        if (cur_ff.rxBitCnt == 3'h0 && cur_ff.rxByteCnt >= hcs_pkg::HCS_MIN_BYTES &&
                            cur_ff.rxCrc == hcs_pkg::HCS_CRC_RESIDUE) begin
                            nxt_state.rxEvt.frameGood = 1'b1;
                        end else begin
                            nxt_state.rxEvt.crcInvalid = 1'b1;
                        end
                    end
                    nxt_state.rxState   = hcs_pkg::HCS_RX_FRAME;
                    nxt_state.rxCrc     = hcs_pkg::HCS_CRC_PRESET;
                    nxt_state.rxDlyCnt  = 3'h0;
                    nxt_state.rxBitCnt  = 3'h0;
                    nxt_state.rxByteCnt = 3'h0;
                end else if (cur_ff.rxOnes != hcs_pkg::HCS_STUFF_ONES) begin
                    pushBit = 1'b1;
                end
            end
        end

        // seven-bit delay keeps flag bits out of the crc and data
        if (pushBit && cur_ff.rxState == hcs_pkg::HCS_RX_FRAME) begin
            nxt_state.rxDly = {rxBit, cur_ff.rxDly[6:1]};
            if (cur_ff.rxDlyCnt != hcs_pkg::HCS_RX_DELAY) begin
                nxt_state.rxDlyCnt = cur_ff.rxDlyCnt + 3'h1;
            end else begin
                nxt_state.rxCrc    = rxCrcStep;
                nxt_state.rxAsm    = {rxExitBit, cur_ff.rxAsm[7:1]};
                nxt_state.rxBitCnt = cur_ff.rxBitCnt + 3'h1;
                if (cur_ff.rxBitCnt == hcs_pkg::HCS_BIT_LAST) begin
                    nxt_state.rxEvt.data      = {rxExitBit, cur_ff.rxAsm[7:1]};
                    nxt_state.rxEvt.byteValid = 1'b1;
                    if (cur_ff.rxByteCnt != hcs_pkg::HCS_BIT_LAST) begin
                        nxt_state.rxByteCnt = cur_ff.rxByteCnt + 3'h1;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff           <= '0;
            cur_ff.txState   <= hcs_pkg::HCS_TX_FLAG;
            cur_ff.rxState   <= hcs_pkg::HCS_RX_HUNT;
            cur_ff.txCrc     <= hcs_pkg::HCS_CRC_PRESET;
            cur_ff.rxCrc     <= hcs_pkg::HCS_CRC_PRESET;
            cur_ff.txBit     <= hcs_pkg::HCS_LINE_IDLE;
            cur_ff.syncA     <= hcs_pkg::HCS_SYNC_IDLE;
            cur_ff.syncB     <= hcs_pkg::HCS_SYNC_IDLE;
            cur_ff.rxClkPrev <= 1'b1;
            cur_ff.serialOut <= hcs_pkg::HCS_LINE_IDLE;
        end else begin
            cur_ff <= nxt_state;
        end
    end

endmodule : hcs_serial_path
`default_nettype wire
